/* File: pkg/tbg_pkg.sv */
// constants, carriers and mode decode for the timer 2 baud generator
// assumes one clock domain and an AXI4-Lite master with 8-bit addresses
//
// Contract
// R1: tx select: 0 timer 1, 1 timer 2
// R2: rx select independent, same encoding
// R3: rollover reloads count from reload bytes
// R4: bit rate is overflow rate over sixteen
// R5: baud: osc or osc/2; else per machine cycle
// R6: rate equals fosc over n times (65536-reload)
// R7: baud behaviour only with a select set
// R8: baud rollover sets no flag, no request
// R9: baud trigger edge sets flag, no reload
// R10: pin counting also divides by sixteen
// R11: software stops timer before touching counts
// R12: baud set-up values include run bit
// R13: other set-up values exclude run bit
// R14: counter set-up values per trigger control
// R15: trigger capture/reload except in baud mode
// R16: missing stop bit sets framing error flag
// R17: serial bit 7 is flag or mode bit
// R18: framing error flag cleared by software only
// R19: enabled edge flag raises interrupt request
// R20: run clear holds count, no pulses
// R21: one-cycle overflow pulses, separate tx/rx paths
package tbg_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          PRE_W        = 4;

  // register byte addresses
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_COUNT    = 8'h04;
  localparam logic [7:0]  OFS_RELOAD   = 8'h08;
  localparam logic [7:0]  OFS_SERIAL   = 8'h0C;
  localparam logic [7:0]  OFS_POWER    = 8'h10;
  localparam logic [7:0]  OFS_CFG      = 8'h14;
  localparam logic [7:0]  OFS_STATUS   = 8'h18;

  // timer_control_reg fields, then serial, power and cfg bits
  localparam int          CTL_ROLL     = 7;
  localparam int          CTL_EDGE     = 6;
  localparam int          CTL_RXSEL    = 5;
  localparam int          CTL_TXSEL    = 4;
  localparam int          CTL_EDGE_EN  = 3;
  localparam int          CTL_RUN      = 2;
  localparam int          CTL_CNT_SEL  = 1;
  localparam int          CTL_CAPT     = 0;
  localparam int          SER_BIT7     = 7;
  localparam int          PWR_B7_SEL   = 6;
  localparam int          CFG_TWELVE   = 0;
  localparam int          CFG_IRQ_EN   = 1;

  // reset values
  localparam logic [7:0]  RST_CTRL     = 8'h00;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [15:0] RST_RELOAD   = 16'h0000;
  localparam logic [7:0]  RST_SERIAL   = 8'h00;
  localparam logic [7:0]  RST_POWER    = 8'h00;
  localparam logic [1:0]  RST_CFG      = 2'h0;

  // last prescaler state: machine cycle of 6 or 12 clocks, baud 1 or 2; then last count
  localparam logic [3:0]  MC_LAST_6    = 4'h5;
  localparam logic [3:0]  MC_LAST_12   = 4'hB;
  localparam logic [3:0]  BAUD_LAST_6  = 4'h0;
  localparam logic [3:0]  BAUD_LAST_12 = 4'h1;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

  // software set-up codes of timer_control_reg
  localparam logic [7:0]  SET_RELOAD_INT  = 8'h00;
  localparam logic [7:0]  SET_RELOAD_EXT  = 8'h08;
  localparam logic [7:0]  SET_CAPT_INT    = 8'h01;
  localparam logic [7:0]  SET_CAPT_EXT    = 8'h09;
  localparam logic [7:0]  SET_BAUD_INT    = 8'h34;
  localparam logic [7:0]  SET_BAUD_EXT    = 8'h36;
  localparam logic [7:0]  SET_RX_INT      = 8'h24;
  localparam logic [7:0]  SET_RX_EXT      = 8'h26;
  localparam logic [7:0]  SET_TX_INT      = 8'h14;
  localparam logic [7:0]  SET_TX_EXT      = 8'h16;
  localparam logic [7:0]  SET_CNT_RLD_INT = 8'h02;
  localparam logic [7:0]  SET_CNT_RLD_EXT = 8'h0A;
  localparam logic [7:0]  SET_CNT_CAP_INT = 8'h03;
  localparam logic [7:0]  SET_CNT_CAP_EXT = 8'h0B;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'h0,
    MODE_RELOAD  = 2'h1,
    MODE_CAPTURE = 2'h3,
    MODE_BAUD    = 2'h2
  } tbg_mode_e;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } tbg_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tbg_axi_rsp_s;

  typedef struct packed {
    logic [2:0] stage;
    logic       stable;
    logic       fall;
  } tbg_sync_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } tbg_div_s;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [15:0]       count;
    logic [15:0]       reload;
    logic [7:0]        serial;
    logic              fe;
    logic [7:0]        power;
    logic [1:0]        cfg;
    logic [PRE_W-1:0]  pre;
    logic              irq;
    logic              tx_ovf;
    logic              rx_ovf;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    tbg_axi_rsp_s      rsp;
  } tbg_state_s;

  // every reset value above is zero, so the whole state clears at once
  localparam tbg_state_s ST_RESET = '0;

  function automatic tbg_mode_e tbg_mode(input logic [7:0] ctrl);
    if (!ctrl[CTL_RUN]) begin
      return MODE_OFF;
    end else if (ctrl[CTL_RXSEL] || ctrl[CTL_TXSEL]) begin
      return MODE_BAUD; // R7 R12
    end else if (ctrl[CTL_CAPT]) begin
      return MODE_CAPTURE; // R13 R14
    end
    return MODE_RELOAD;
  endfunction : tbg_mode

endpackage : tbg_pkg

/* File: logic/tbg_sync.sv */
// three-stage pin synchroniser with agreement filter and fall pulse
// assumes pin is asynchronous to clk_sys; reset already synchronised
`timescale 1ns/100ps
module tbg_sync
  import tbg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  tbg_sync_s s_q;
  tbg_sync_s s_d;

  always_comb begin
    s_d       = s_q;
    s_d.stage = {s_q.stage[1:0], pin};
    // stage 0 is read only by stage 1
    if (s_q.stage[1] == s_q.stage[2]) begin
      s_d.stable = s_q.stage[2];
    end
    s_d.fall = s_q.stable && !s_d.stable;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.stable;
  assign fall  = s_q.fall;

endmodule : tbg_sync

/* File: logic/tbg_div.sv */
// divides a stream of one-cycle pulses by DIV, one-cycle output pulse
// assumes input pulses are at most one per clock
`timescale 1ns/100ps
module tbg_div
  import tbg_pkg::*;
#(
  parameter int DIV = 16
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic tick_in,
  output logic      tick_out
);

  if (DIV < 2 || DIV > 256) begin : g_bad_div
    $error("tbg_div: DIV must be 2 to 256");
  end

  localparam logic [7:0] LAST = 8'(DIV - 1);

  tbg_div_s s_q;
  tbg_div_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (tick_in) begin
      if (s_q.cnt == LAST) begin
        s_d.cnt  = 8'h00;
        s_d.tick = 1'b1; // R4 R10
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

endmodule : tbg_div

/* File: logic/tbg_timer2_baud.sv */
// timer 2 with baud rate generation, serial rate selection and
// framing error flag, all registers on an AXI4-Lite slave
// assumes clk_sys is the oscillator; timer1_overflow, rx_frame_done
// and rx_stop_bit come from logic on clk_sys
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module tbg_timer2_baud
  import tbg_pkg::*;
#(
  parameter int BAUD_DIV = 16
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  input  tbg_axi_req_s axi_req,
  output tbg_axi_rsp_s axi_rsp,
  input  wire logic   external_count_pin,
  input  wire logic   trigger_input,
  input  wire logic   timer1_overflow,
  input  wire logic   rx_frame_done,
  input  wire logic   rx_stop_bit,
  output logic        tx_sample_tick,
  output logic        rx_sample_tick,
  output logic        tx_bit_tick,
  output logic        rx_bit_tick,
  output logic        serial_mode_bit0,
  output logic        framing_error_flag,
  output logic        timer_irq
);

  if (BAUD_DIV < 2 || BAUD_DIV > 256) begin : g_bad_div
    $error("tbg_timer2_baud: BAUD_DIV must be 2 to 256");
  end

  //////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_q;
  logic       rst_n_int;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////
  // pin inputs

  logic count_pin_fall;
  logic trig_fall;

  // pin counting is asynchronous to the oscillator, so it is resampled
  tbg_sync u_count_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_int),
    .pin     (external_count_pin),
    .level   (),
    .fall    (count_pin_fall)
  );

  tbg_sync u_trig_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_int),
    .pin     (trigger_input),
    .level   (),
    .fall    (trig_fall)
  );

  //////////////////////////////////////////////////////////////////////
  // state

  tbg_state_s s_q;
  tbg_state_s s_d;
  tbg_mode_e  mode;

  assign mode = tbg_mode(s_q.ctrl);

  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'h0};
  endfunction : word_of

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    case (word_of(a))
      OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_SERIAL,
      OFS_POWER, OFS_CFG, OFS_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mapped

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  logic [31:0]      rd_word;
  logic             wr_en;
  logic [PRE_W-1:0] pre_last;
  logic             pre_wrap;
  logic             inc;
  logic             ovf;
  logic             trig;

  //////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    rd_word = 32'h0000_0000;
    case (word_of(axi_req.araddr))
      OFS_CTRL:   rd_word = {24'h00_0000, s_q.ctrl};
      OFS_COUNT:  rd_word = {16'h0000, s_q.count};
      OFS_RELOAD: rd_word = {16'h0000, s_q.reload};
      OFS_SERIAL: begin
        rd_word = {24'h00_0000, s_q.serial};
        // bit 7 shows the flag or the mode bit
        rd_word[SER_BIT7] = s_q.power[PWR_B7_SEL] ?
                            s_q.fe : s_q.serial[SER_BIT7]; // R17
      end
      OFS_POWER:  rd_word = {24'h00_0000, s_q.power};
      OFS_CFG:    rd_word = {30'h0000_0000, s_q.cfg};
      OFS_STATUS: rd_word = {30'h0000_0000, mode};
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d   = s_q;
    wr_en = s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid;

    // bus channels
    if (axi_req.bready && s_q.rsp.bvalid) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (axi_req.rready && s_q.rsp.rvalid) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (axi_req.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = rd_word;
      s_d.rsp.rresp  = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // software writes; hardware events below override them
    if (wr_en) begin
      s_d.aw_got     = 1'b0;
      s_d.w_got      = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wstrb[0]) begin
        case (word_of(s_q.aw_addr))
          OFS_CTRL:  s_d.ctrl  = s_q.wdata[7:0];
          OFS_POWER: s_d.power = s_q.wdata[7:0];
          OFS_CFG:   s_d.cfg   = s_q.wdata[1:0];
          OFS_SERIAL: begin
            if (s_q.power[PWR_B7_SEL]) begin
              // writing 1 keeps the flag; only 0 clears it
              s_d.fe = s_q.fe && s_q.wdata[SER_BIT7]; // R17 R18
              s_d.serial[SER_BIT7-1:0] = s_q.wdata[SER_BIT7-1:0];
            end else begin
              s_d.serial = s_q.wdata[7:0]; // R17
            end
          end
          default: ;
        endcase
      end
      // counts are taken as written; stopping first is up to software
      case (word_of(s_q.aw_addr))
        OFS_COUNT:  s_d.count  = merge16(s_q.count, s_q.wdata,
                                         s_q.wstrb); // R11
        OFS_RELOAD: s_d.reload = merge16(s_q.reload, s_q.wdata,
                                         s_q.wstrb); // R11
        default: ;
      endcase
    end

    // prescaler: oscillator or half in baud mode, else machine cycle
    if (mode == MODE_BAUD) begin
      pre_last = s_q.cfg[CFG_TWELVE] ? BAUD_LAST_12 : BAUD_LAST_6; // R5 R6
    end else begin
      pre_last = s_q.cfg[CFG_TWELVE] ? MC_LAST_12 : MC_LAST_6; // R5
    end
    pre_wrap = s_q.pre >= pre_last;
    if (!s_q.ctrl[CTL_RUN]) begin
      s_d.pre = '0; // R20
    end else if (pre_wrap) begin
      s_d.pre = '0;
    end else begin
      s_d.pre = s_q.pre + 4'h1;
    end

    inc = s_q.ctrl[CTL_RUN] &&
          (s_q.ctrl[CTL_CNT_SEL] ? count_pin_fall : pre_wrap); // R10 R20
    ovf  = inc && (s_q.count == COUNT_MAX);
    trig = trig_fall && s_q.ctrl[CTL_EDGE_EN];

    if (ovf) begin
      // capture mode wraps to zero, the others reload
      s_d.count = (mode == MODE_CAPTURE) ? RST_COUNT : s_q.reload; // R3
    end else if (inc) begin
      s_d.count = s_q.count + 16'h0001;
    end

    // no trigger reload while generating baud rates
    if (trig && mode == MODE_RELOAD) begin
      s_d.count = s_q.reload; // R15
    end
    if (trig && mode == MODE_CAPTURE) begin
      s_d.reload = s_q.count; // R15
    end
    if (trig) begin
      s_d.ctrl[CTL_EDGE] = 1'b1; // R9 R15
    end
    if (ovf && mode != MODE_BAUD) begin
      s_d.ctrl[CTL_ROLL] = 1'b1; // R8
    end

    // per-direction source selection, one-cycle pulses
    s_d.tx_ovf = s_q.ctrl[CTL_TXSEL] ? ovf : timer1_overflow; // R1 R21
    s_d.rx_ovf = s_q.ctrl[CTL_RXSEL] ? ovf : timer1_overflow; // R2 R21

    if (rx_frame_done && !rx_stop_bit) begin
      s_d.fe = 1'b1; // R16 R18
    end

    // rollover flag never sets in baud mode, so only the edge asks there
    s_d.irq = s_q.cfg[CFG_IRQ_EN] &&
              (s_d.ctrl[CTL_ROLL] || s_d.ctrl[CTL_EDGE]); // R19 R8

    // readies follow from the next channel state
    s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
    s_d.rsp.wready  = !s_d.w_got && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bit-rate dividers, one per direction

  // the serial port gets both the raw overflow and the divided tick
  tbg_div #(
    .DIV (BAUD_DIV)
  ) u_tx_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n_int),
    .tick_in  (s_q.tx_ovf),
    .tick_out (tx_bit_tick)
  );

  tbg_div #(
    .DIV (BAUD_DIV)
  ) u_rx_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n_int),
    .tick_in  (s_q.rx_ovf),
    .tick_out (rx_bit_tick)
  );

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign axi_rsp            = s_q.rsp;
  assign tx_sample_tick     = s_q.tx_ovf;
  assign rx_sample_tick     = s_q.rx_ovf;
  assign serial_mode_bit0   = s_q.serial[SER_BIT7];
  assign framing_error_flag = s_q.fe;
  assign timer_irq          = s_q.irq;

endmodule : tbg_timer2_baud

/* File: bench/tbg_timer2_baud_checker.sv */
// port assertions for the timer 2 baud generator top
// assumes one clock domain; bound onto every tbg_timer2_baud
`timescale 1ns/100ps
module tbg_timer2_baud_checker
  import tbg_pkg::*;
#(
  parameter int BAUD_DIV = 16
) (
  input wire logic   clk_sys,
  input wire logic   rst_n,
  input tbg_axi_req_s axi_req,
  input tbg_axi_rsp_s axi_rsp,
  input wire logic   rx_frame_done,
  input wire logic   rx_stop_bit,
  input wire logic   tx_sample_tick,
  input wire logic   rx_sample_tick,
  input wire logic   tx_bit_tick,
  input wire logic   rx_bit_tick,
  input wire logic   serial_mode_bit0,
  input wire logic   framing_error_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [1:0] live_q;
  logic [8:0] txn_q;
  logic [8:0] rxn_q;
  ////////////////////////////////////////////////////////////////////
  // sample ticks not yet turned into a bit tick, per direction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      live_q <= 2'h0;
      txn_q <= 9'h000;
      rxn_q <= 9'h000;
    end else begin
      live_q <= (live_q == 2'h3) ? live_q : live_q + 2'h1;
      txn_q <= txn_q + 9'(tx_sample_tick) - 9'(tx_bit_tick ? BAUD_DIV : 0);
      rxn_q <= rxn_q + 9'(rx_sample_tick) - 9'(rx_bit_tick ? BAUD_DIV : 0);
    end
  end
  ////////////////////////////////////////////////////////////////////
  property p_fe_set;
    live_q == 2'h3 && rx_frame_done && !rx_stop_bit |=> framing_error_flag;
  endproperty
  a_fe_set: assert property (p_fe_set)
    else $error("flag not set");
  // only a register write may drop the flag or change the mode bit
  property p_fe_hold;
    $fell(framing_error_flag) |-> !axi_rsp.awready || !$past(axi_rsp.awready);
  endproperty
  a_fe_hold: assert property (p_fe_hold)
    else $error("flag dropped");
  property p_mode_hold;
    !$stable(serial_mode_bit0) |-> !axi_rsp.awready || !$past(axi_rsp.awready);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode bit moved");
  property p_tx_div;
    tx_bit_tick == (txn_q == 9'(BAUD_DIV));
  endproperty
  a_tx_div: assert property (p_tx_div)
    else $error("tx bit tick off");
  property p_rx_div;
    rx_bit_tick == (rxn_q == 9'(BAUD_DIV));
  endproperty
  a_rx_div: assert property (p_rx_div)
    else $error("rx bit tick off");
  property p_b_time;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
  endproperty
  a_b_time: assert property (p_b_time)
    else $error("b timing off");
  property p_aw_refuse;
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse)
    else $error("write taken early");
  property p_r_time;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
  endproperty
  a_r_time: assert property (p_r_time)
    else $error("r timing off");
  c_txbit: cover property (tx_bit_tick);
  c_rxbit: cover property (rx_bit_tick);
  c_fe: cover property ($rose(framing_error_flag));
endmodule : tbg_timer2_baud_checker

bind tbg_timer2_baud tbg_timer2_baud_checker #(.BAUD_DIV(BAUD_DIV)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .rx_frame_done(rx_frame_done), .rx_stop_bit(rx_stop_bit),
  .tx_sample_tick(tx_sample_tick), .rx_sample_tick(rx_sample_tick),
  .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick),
  .serial_mode_bit0(serial_mode_bit0),
  .framing_error_flag(framing_error_flag));

/* File: bench/tbg_serial_model.sv */
// serial port stand-in: timer 1 overflows and receive frame ends
// assumes rx_bit_tick is the receive bit rate; ten bits a frame
`timescale 1ns/100ps
module tbg_serial_model #(
  parameter int T1_PER = 3
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic bad_stop,
  input  wire logic rx_bit_tick,
  output logic      timer1_overflow,
  output logic      rx_frame_done,
  output logic      rx_stop_bit
);
  int t1_n;
  int bit_n;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t1_n <= 0;
      bit_n <= 0;
      timer1_overflow <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_stop_bit <= 1'b0;
    end else begin
      t1_n <= (t1_n == T1_PER - 1) ? 0 : t1_n + 1;
      timer1_overflow <= (t1_n == T1_PER - 1);
      rx_frame_done <= 1'b0;
      // meaningless outside a frame end, so keep it moving
      rx_stop_bit <= !rx_stop_bit;
      if (rx_bit_tick) begin
        bit_n <= (bit_n == 9) ? 0 : bit_n + 1;
        if (bit_n == 9) begin
          rx_frame_done <= 1'b1;
          rx_stop_bit <= !bad_stop;
        end
      end
    end
  end
endmodule : tbg_serial_model

/* File: bench/timer2_baud_rate_generator_bench.sv */
// self-checking bench for the timer 2 baud generator
// assumes the design top, checker bind and serial model
`timescale 1ns/100ps
module timer2_baud_rate_generator_bench
  import tbg_pkg::*;
;
  localparam int BD = 4;
  localparam int T1 = 3;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  tbg_axi_req_s axi_req = '0;
  tbg_axi_rsp_s axi_rsp;
  logic         pin = 1'b1;
  logic         trig = 1'b1;
  logic         bad = 1'b0;
  logic         t1_ovf, fr_done, stop_bit;
  logic         tx_s, rx_s, tx_b, rx_b, mode0, fe, irq;
  logic [3:0]   tk;
  logic [33:0]  exp_q[$];
  logic [31:0]  rnd = 32'h9;
  int           num_errors = 0;
  int           compares = 0;
  int           n_txs = 0;
  int           g, ex, n0;
  logic [7:0]   codes[14] = '{SET_RELOAD_INT, SET_RELOAD_EXT, SET_CAPT_INT,
    SET_CAPT_EXT, SET_BAUD_INT, SET_BAUD_EXT, SET_RX_INT, SET_RX_EXT,
    SET_TX_INT, SET_TX_EXT, SET_CNT_RLD_INT, SET_CNT_RLD_EXT,
    SET_CNT_CAP_INT, SET_CNT_CAP_EXT};
  logic [7:0]   bcode[3] = '{SET_TX_INT, SET_RX_INT, SET_BAUD_INT};
  logic [7:0]   regs[7] = '{OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_SERIAL,
    OFS_POWER, OFS_CFG, OFS_STATUS};

  always #20 clk_sys = ~clk_sys;
  assign tk = {rx_b, tx_b, rx_s, tx_s};

  tbg_timer2_baud #(.BAUD_DIV(BD)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .external_count_pin(pin), .trigger_input(trig),
    .timer1_overflow(t1_ovf), .rx_frame_done(fr_done),
    .rx_stop_bit(stop_bit), .tx_sample_tick(tx_s), .rx_sample_tick(rx_s),
    .tx_bit_tick(tx_b), .rx_bit_tick(rx_b), .serial_mode_bit0(mode0),
    .framing_error_flag(fe), .timer_irq(irq));
  tbg_serial_model #(.T1_PER(T1)) u_ser (
    .clk_sys(clk_sys), .rst_n(rst_n), .bad_stop(bad), .rx_bit_tick(rx_b),
    .timer1_overflow(t1_ovf), .rx_frame_done(fr_done),
    .rx_stop_bit(stop_bit));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [1:0] emode(input logic [7:0] c);
    if (!c[CTL_RUN]) return MODE_OFF;
    if (c[CTL_RXSEL] || c[CTL_TXSEL]) return MODE_BAUD;
    return c[CTL_CAPT] ? MODE_CAPTURE : MODE_RELOAD;
  endfunction : emode

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    exp_q.push_back({r, 32'h0});
    @(posedge clk_sys);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge clk_sys);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
  endtask : rd

  // cycles between two ticks of one output; drops trigger at cycle k
  task automatic gap(input int i, input int k, output int gp);
    gp = 0;
    do begin
      @(posedge clk_sys);
      gp++;
    end while (tk[i] !== 1'b1 && gp < 2000);
    gp = 0;
    do begin
      @(posedge clk_sys);
      gp++;
      if (gp == k) trig <= 1'b0;
    end while (tk[i] !== 1'b1 && gp < 2000);
  endtask : gap

  // slow pulses so the three-stage synchroniser sees every fall
  task automatic falls(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      pin <= 1'b1;
    end
    repeat (8) @(posedge clk_sys);
  endtask : falls

  task automatic tfall;
    trig <= 1'b0;
    repeat (8) @(posedge clk_sys);
    trig <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : tfall
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (axi_rsp.bvalid && axi_req.bready)
      chk({axi_rsp.bresp, 32'h0}, exp_q.pop_front());
    if (axi_rsp.rvalid && axi_req.rready)
      chk({axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front());
    if (tx_s) n_txs++;
  end

  initial begin
    #(40 * 60000);
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    foreach (regs[j]) rd(regs[j], 32'h0);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    foreach (codes[j]) begin
      wr(OFS_CTRL, {24'h0, codes[j]});
      rd(OFS_STATUS, {30'h0, emode(codes[j])});
      wr(OFS_CTRL, {24'h0, codes[j] | 8'h04});
      rd(OFS_STATUS, {30'h0, emode(codes[j] | 8'h04)});
      wr(OFS_CTRL, 32'h0);
    end
    wr(OFS_RELOAD, 32'hFFF0);
    wr(OFS_COUNT, 32'hFFF0);
    for (int tw = 0; tw < 2; tw++) begin
      wr(OFS_CFG, 32'(tw) | 32'h2);
      foreach (bcode[j]) begin
        wr(OFS_CTRL, {24'h0, bcode[j]});
        for (int i = 0; i < 4; i++) begin
          gap(i, 0, g);
          ex = (bcode[j][CTL_TXSEL + i % 2] ? 16 * (tw + 1) : T1) *
               (i > 1 ? BD : 1);
          chk(34'(g), 34'(ex));
        end
        rd(OFS_CTRL, {24'h0, bcode[j]});
        chk({33'h0, irq}, 34'h0);
      end
    end
    wr(OFS_CTRL, 32'h10);
    rnd = xs(rnd);
    wr(OFS_COUNT, {16'h0, rnd[15:0]});
    n0 = n_txs;
    repeat (100) @(posedge clk_sys);
    rd(OFS_COUNT, {16'h0, rnd[15:0]});
    chk(34'(n_txs - n0), 34'h0);
    wr(OFS_COUNT, 32'hFFF0);
    wr(OFS_CFG, 32'h2);
    wr(OFS_CTRL, 32'h1C);
    gap(0, 6, g);
    chk(34'(g), 34'd16);
    trig <= 1'b1;
    rd(OFS_CTRL, 32'h5C);
    chk({33'h0, irq}, 34'h1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, {24'h0, SET_CNT_CAP_EXT | 8'h04});
    falls(5);
    tfall();
    rd(OFS_RELOAD, 32'h5);
    rd(OFS_CTRL, 32'h4F);
    wr(OFS_CTRL, {24'h0, SET_CNT_RLD_EXT | 8'h04});
    falls(2);
    tfall();
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT, 32'h5);
    wr(OFS_RELOAD, 32'hFFFE);
    wr(OFS_COUNT, 32'hFFFE);
    wr(OFS_CTRL, {24'h0, SET_TX_EXT});
    n0 = n_txs;
    falls(2 * BD * 3);
    chk(34'(n_txs - n0), 34'(BD * 3));
    wr(OFS_POWER, 32'h40);
    bad <= 1'b1;
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (fe !== 1'b1 && g < 500);
    bad <= 1'b0;
    chk({33'h0, fe}, 34'h1);
    rd(OFS_SERIAL, 32'h80);
    repeat (300) @(posedge clk_sys);
    chk({33'h0, fe}, 34'h1);
    wr(OFS_SERIAL, 32'h0);
    rd(OFS_SERIAL, 32'h0);
    wr(OFS_POWER, 32'h0);
    wr(OFS_SERIAL, 32'h80);
    rd(OFS_SERIAL, 32'h80);
    chk({33'h0, mode0}, 34'h1);
    give_verdict();
  end
endmodule : timer2_baud_rate_generator_bench
